// ===== inc/sbcs_defines.vh
`ifndef SBCS_DEFINES_VH
`define SBCS_DEFINES_VH
// Divider field position inside the channel data/divider word
`define SBCS_DIV_MSB 15
`define SBCS_DIV_LSB 9
`define SBCS_DIV_W 7
`define SBCS_DIV_MIN 7'h02
`define SBCS_DIV_MAX 7'h7f
// Prescaler code layout and special values
`define SBCS_PRS_W 4
`define SBCS_PRS_MAX_DIV 4'hb
`define SBCS_PRS_TIMER 4'hf
`define SBCS_PRS_CNT_W 11
`define SBCS_PRS_TAPS 12
// Bit-rate generator states (one-hot)
`define SBCS_ST_IDLE 2'h1
`define SBCS_ST_RUN 2'h2
`endif

// ===== logic/sbcs_prescaler.v
`timescale 1ns/100ps
`include "sbcs_defines.vh"
// Free-running power-of-two prescaler; one enable pulse per tap
module sbcs_prescaler #(
	parameter TAPS = 12
) (
	input wire sys_clk,
	input wire rst_n,
	output wire [TAPS-1:0] tap_pulse
);
	reg [TAPS-2:0] cnt_reg;
	wire [TAPS-2:0] cnt_next;

	assign cnt_next = cnt_reg + {{(TAPS-2){1'b0}}, 1'b1};

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= {(TAPS-1){1'b0}};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Tap k pulses once every 2^k clocks; tap 0 is every clock
	assign tap_pulse[0] = 1'b1;
	genvar k;
	generate
		for (k = 1; k < TAPS; k = k + 1) begin : g_tap
			assign tap_pulse[k] = &cnt_reg[k-1:0];
		end
	endgenerate
endmodule // sbcs_prescaler

// ===== logic/sbcs_baud_gen.v
`timescale 1ns/100ps
`include "sbcs_defines.vh"
module sbcs_baud_gen #(
	parameter UNIT_IS_ZERO = 1
) (
	input wire sys_clk,
	input wire nrst,
	input wire [15:0] channel_data_divider_reg,
	input wire [7:0] unit_prescaler_select,
	input wire channel_clock_select_bit,
	input wire channel_enable,
	input wire timer_ch2_interrupt_clock,
	output wire channel_operation_clock,
	output wire baud_tick,
	output wire baud_clk,
	output wire config_error
);
	////////////////////////////////////////////////////////////////////////
	// Reset is applied at once but released only on a clock edge
	reg rst_sync1_reg;
	reg rst_sync2_reg;
	wire rst_n;

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	////////////////////////////////////////////////////////////////////////
	// Timer interrupt is treated as foreign: synchronise, then edge-detect
	// Levels shorter than one clock can be lost; the timer is far slower
	reg tmr_sync1_reg;
	reg tmr_sync2_reg;
	reg tmr_last_reg;
	wire tmr_pulse;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_sync1_reg <= 1'b0;
			tmr_sync2_reg <= 1'b0;
			tmr_last_reg <= 1'b0;
		end else begin
			tmr_sync1_reg <= timer_ch2_interrupt_clock;
			tmr_sync2_reg <= tmr_sync1_reg;
			tmr_last_reg <= tmr_sync2_reg;
		end
	end
	assign tmr_pulse = tmr_sync2_reg & ~tmr_last_reg;

	////////////////////////////////////////////////////////////////////////
	localparam NUM_TAPS = `SBCS_PRS_TAPS;

	wire [NUM_TAPS-1:0] tap_pulse;

	sbcs_prescaler #(
		.TAPS(NUM_TAPS)
	) sbcs_prescaler_inst (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tap_pulse(tap_pulse)
	);

	wire [3:0] lower_prescaler_code;
	wire [3:0] upper_prescaler_code;
	wire [3:0] sel_code;
	reg mck_en;
	reg code_bad;

	// Configuration comes from logic on this clock, so it is used as is
	assign lower_prescaler_code = unit_prescaler_select[3:0];
	assign upper_prescaler_code = unit_prescaler_select[7:4];
	// The unused nibble never reaches the selection
	assign sel_code = channel_clock_select_bit ? upper_prescaler_code :
		lower_prescaler_code;

	// One-hot decode of the code, then one AND per tap: a flat AND-OR
	// instead of a variable index, and reserved codes hit no tap at all
	wire [15:0] code_hot;
	wire [NUM_TAPS-1:0] tap_hit;
	wire tap_en;

	assign code_hot = 16'h0001 << sel_code;

	genvar t;
	generate
		for (t = 0; t < NUM_TAPS; t = t + 1) begin : g_tap_sel
			assign tap_hit[t] = tap_pulse[t] & code_hot[t];
		end
	endgenerate
	assign tap_en = |tap_hit;

	always @* begin
		mck_en = 1'b0;
		code_bad = 1'b0;
		if (sel_code <= `SBCS_PRS_MAX_DIV) begin
			mck_en = tap_en;
		end else if (sel_code == `SBCS_PRS_TIMER) begin
			if (UNIT_IS_ZERO != 0) begin
				mck_en = tmr_pulse;
			end else begin
				code_bad = 1'b1;
			end
		end else begin
			// Reserved codes give no clock at all
			code_bad = 1'b1;
		end
	end

	// One-cycle enable standing in for the channel operation clock
	assign channel_operation_clock = mck_en;

	////////////////////////////////////////////////////////////////////////
	wire [6:0] div_field;
	wire div_bad;

	// Only the divider field counts; the low data bits are ignored
	assign div_field =
		channel_data_divider_reg[`SBCS_DIV_MSB:`SBCS_DIV_LSB];
	// Forbidden divider values are flagged and halt the generator
	assign div_bad = div_field < `SBCS_DIV_MIN;

	// Generator is either parked or counting half bits
	localparam ST_IDLE = `SBCS_ST_IDLE;
	localparam ST_RUN = `SBCS_ST_RUN;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [6:0] cnt_reg;
	reg [6:0] cnt_next;
	reg half_done;
	reg tick_next;
	reg clk_next;
	reg err_next;
	reg baud_tick_reg;
	reg baud_clk_reg;
	reg config_error_reg;

	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		clk_next = baud_clk_reg;
		err_next = div_bad | code_bad;
		half_done = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				cnt_next = 7'h00;
				clk_next = 1'b0;
				if (channel_enable && !div_bad && !code_bad) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!channel_enable || div_bad || code_bad) begin
					state_next = ST_IDLE;
					cnt_next = 7'h00;
					clk_next = 1'b0;
				end else if (mck_en) begin
					// div+1 operation-clock cycles per half bit, two halves
					half_done = (cnt_reg == div_field);
					if (half_done) begin
						cnt_next = 7'h00;
						clk_next = ~baud_clk_reg;
						tick_next = baud_clk_reg;
					end else begin
						cnt_next = cnt_reg + 7'h01;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = 7'h00;
				clk_next = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 7'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tick, bit clock and error outputs straight from flip-flops so a receiver sees no glitches
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_tick_reg <= 1'b0;
			baud_clk_reg <= 1'b0;
			config_error_reg <= 1'b0;
		end else begin
			baud_tick_reg <= tick_next;
			baud_clk_reg <= clk_next;
			config_error_reg <= err_next;
		end
	end

	assign baud_tick = baud_tick_reg;
	assign baud_clk = baud_clk_reg;
	assign config_error = config_error_reg;

	// Changing the system clock is safe only with the channel disabled;
	// software owns the stop sequence, the block just restarts cleanly
	// when channel_enable returns.
endmodule // sbcs_baud_gen

// ===== bench/sbcs_checker_props.sv
`timescale 1ns/100ps
module sbcs_checker (
	input wire sys_clk,
	input wire nrst,
	input wire [15:0] channel_data_divider_reg,
	input wire [7:0] unit_prescaler_select,
	input wire channel_clock_select_bit,
	input wire channel_enable,
	input wire timer_ch2_interrupt_clock,
	input wire channel_operation_clock,
	input wire baud_tick,
	input wire baud_clk,
	input wire config_error
);
	wire [3:0] code = channel_clock_select_bit ?
		unit_prescaler_select[7:4] : unit_prescaler_select[3:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_tick_edge: assert property (baud_tick |->
		$past(baud_clk) && !baud_clk)
		else $error("tick without bit clock fall");
	chk_tick_single: assert property (baud_tick |=> !baud_tick)
		else $error("tick longer than one cycle");
	chk_idle_low: assert property (!channel_enable |=> !baud_clk)
		else $error("bit clock runs while stopped");
	chk_code_zero: assert property (code == 4'h0 |->
		channel_operation_clock)
		else $error("code zero must pass every cycle");
	chk_resv_quiet: assert property (code > 4'hb && code < 4'hf |->
		!channel_operation_clock)
		else $error("reserved code gives an operation clock");
	chk_code_one: assert property ((code == 4'h1) [*6] |->
		channel_operation_clock != $past(channel_operation_clock))
		else $error("code one must alternate");
	chk_timer_quiet: assert property ((code == 4'hf &&
		!timer_ch2_interrupt_clock) [*5] |-> !channel_operation_clock)
		else $error("timer source pulses without timer edge");
	chk_bad_div: assert property ((channel_enable &&
		channel_data_divider_reg[15:9] < 7'h02) [*4] |-> config_error)
		else $error("divider below two not flagged");
endmodule // sbcs_checker

// ===== bench/sbcs_timer_src.sv
`timescale 1ns/100ps
// Stands in for the timer channel; stays low when halted
module sbcs_timer_src #(parameter HALF = 8) (
	input wire sys_clk,
	input wire run,
	output logic tick = 1'b0
);
	int cnt = 0;
	always @(posedge sys_clk) begin
		cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
		tick <= run ? tick ^ (cnt == HALF - 1) : 1'b0;
	end
endmodule // sbcs_timer_src

// ===== bench/sbcs_baud_gen_tb.sv
`timescale 1ns/100ps
module sbcs_baud_gen_tb;
	logic sys_clk = 0, nrst = 0, channel_clock_select_bit = 0;
	logic channel_enable = 0, trun = 0;
	logic [15:0] channel_data_divider_reg = 16'h0400;
	logic [7:0] unit_prescaler_select = 8'h00;
	wire timer_ch2_interrupt_clock, channel_operation_clock;
	wire baud_tick, baud_clk, config_error;
	int err_count = 0, cmp_count = 0, cyc = 0, last = 0;
	int expq[$];
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	sbcs_baud_gen sbcs_baud_gen_inst (.sys_clk, .nrst,
		.channel_data_divider_reg, .unit_prescaler_select,
		.channel_clock_select_bit, .channel_enable, .timer_ch2_interrupt_clock,
		.channel_operation_clock, .baud_tick, .baud_clk, .config_error);
	sbcs_timer_src sbcs_timer_src_inst (.sys_clk, .run(trun),
		.tick(timer_ch2_interrupt_clock));
	////////////////////////////////////////
	task complete_run;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp_int(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			err_count++;
			$display("wrong value at %0t: period %0d not %0d", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: flag %b", $time, got);
		end
	endtask
	// Unused nibble and low data bits are random: they must not matter
	task run_case(input [3:0] k, input logic sel, input [6:0] d,
		input int per);
		@(posedge sys_clk);
		unit_prescaler_select <= sel ? {k, 4'($urandom)} : {4'($urandom), k};
		channel_clock_select_bit <= sel;
		channel_data_divider_reg <= {d, 9'($urandom)};
		expq.push_back(per);
		@(posedge sys_clk) channel_enable <= 1'b1;
		wait (expq.size() == 0);
		cmp_bit(config_error, 1'b0);
		@(posedge sys_clk) channel_enable <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	// First tick after enable only marks the start of the measurement
	always @(posedge sys_clk)
		if (!channel_enable)
			last <= 0;
		else if (baud_tick) begin
			if (last != 0 && expq.size() > 0)
				cmp_int(cyc - last, expq.pop_front());
			last <= cyc;
		end
	initial begin
		logic [6:0] d;
		void'($urandom(88));
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// Only legal codes and dividers in the rate runs
		for (int k = 0; k < 12; k++)
			run_case(k, k[0], 7'h02, 6 << k);
		d = 7'h02 + 7'($urandom % 126);
		run_case(4'h1, 1'b1, d, 4 * (d + 1));
		run_case(4'h0, 1'b0, 7'h7f, 256);
		trun <= 1'b1;
		run_case(4'hf, 1'b0, 7'h02, 96);
		trun <= 1'b0;
		// Refusals: a forbidden divider, then a reserved code
		channel_data_divider_reg <= 16'h0200;
		channel_enable <= 1'b1;
		repeat (6) @(posedge sys_clk);
		cmp_bit(config_error, 1'b1);
		cmp_bit(baud_clk, 1'b0);
		channel_enable <= 1'b0;
		channel_data_divider_reg <= 16'h0400;
		unit_prescaler_select <= 8'h0c;
		@(posedge sys_clk) channel_enable <= 1'b1;
		repeat (6) @(posedge sys_clk);
		cmp_bit(config_error, 1'b1);
		cmp_bit(channel_operation_clock, 1'b0);
		cmp_bit(baud_clk, 1'b0);
		complete_run;
	end
	initial begin
		repeat (80000) @(posedge sys_clk);
		err_count++;
		complete_run;
	end
endmodule // sbcs_baud_gen_tb
bind sbcs_baud_gen sbcs_checker sbcs_checker_inst (.sys_clk, .nrst,
	.channel_data_divider_reg, .unit_prescaler_select,
	.channel_clock_select_bit, .channel_enable, .timer_ch2_interrupt_clock,
	.channel_operation_clock, .baud_tick, .baud_clk, .config_error);
